// *** rtl/wsd_input.sv ***
// speed pulse and direction input capture with apb register access
`timescale 1ns/1ps
module wsd_input
    import wsd_pkg::*;
#(
    parameter int CNT_W = 32
)(
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST_B,
    // vehicle pins
    input  wire logic        SPEED_PULSE_INPUT,
    input  wire logic        DIRECTION_INPUT,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // events
    output logic             TICK,
    output logic             TICK_FORWARD,
    output logic             TIME_MARK
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]            sp_sync;
        logic [1:0]            dir_sync;
        logic                  sp_prev;
        logic [WSD_CTRL_W-1:0] ctrl;
        logic                  pol_learned;
        logic                  polarity;
        logic [CNT_W-1:0]      ticks;
        logic [CNT_W-1:0]      marks;
        wsd_bus_t              bus;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  tick;
        logic                  tick_fwd;
        logic                  time_mark;
    } wsd_state_t;

    wsd_state_t r;
    wsd_state_t next_r;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] wsd_zext(input logic [CNT_W-1:0] v);
        // counters wider than the bus word are cut to it
        wsd_zext = 32'(v);
    endfunction

    function automatic logic [CNT_W-1:0] wsd_inc(input logic [CNT_W-1:0] v);
        wsd_inc = v + 1'b1;
    endfunction

    function automatic logic [31:0] wsd_status(
        input logic learned,
        input logic pol,
        input logic direction_input,
        input logic lvl
    );
        wsd_status                     = WSD_ZERO;
        wsd_status[WSD_ST_POL_LEARNED] = learned;
        wsd_status[WSD_ST_POLARITY]    = pol;
        wsd_status[WSD_ST_FORWARD]     = direction_input;
        wsd_status[WSD_ST_PULSE_LVL]   = lvl;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic sp_now;
    logic rise;
    logic fall;
    logic edge_hit;
    logic fwd_now;
    logic wr_ok;

    always_comb
    begin
        next_r = r;
        // ------------------------------------------------------------
        // synchronise pins
        // ------------------------------------------------------------
        // pins are asynchronous: two flops before any use
        next_r.sp_sync  = {r.sp_sync[0], SPEED_PULSE_INPUT};
        next_r.dir_sync = {r.dir_sync[0], DIRECTION_INPUT};
        sp_now          = r.sp_sync[1];
        next_r.sp_prev  = sp_now;
        rise            = sp_now & ~r.sp_prev;
        fall            = ~sp_now & r.sp_prev;
        edge_hit        = rise | (r.ctrl[WSD_CTRL_DUAL_EDGE] & fall);

        // ------------------------------------------------------------
        // direction and polarity
        // ------------------------------------------------------------
        // manual polarity holds learning off
        if (r.ctrl[WSD_CTRL_POL_MAN])
        begin
            next_r.polarity    = r.ctrl[WSD_CTRL_POL_VAL];
        end
        else if (!r.pol_learned && r.ctrl[WSD_CTRL_SPD_OK] && rise)
        begin
            next_r.polarity    = r.dir_sync[1];
            next_r.pol_learned = 1'b1;
        end
        if (r.ctrl[WSD_CTRL_DIR_SW])
            fwd_now = r.ctrl[WSD_CTRL_DIR_SWVAL];
        else
            fwd_now = ~(r.dir_sync[1] ^ next_r.polarity);

        // ------------------------------------------------------------
        // ticks or time marks
        // ------------------------------------------------------------
        next_r.tick      = 1'b0;
        next_r.time_mark = 1'b0;
        next_r.tick_fwd  = fwd_now;
        // time mark mode takes the pulse pin away from tick counting
        if (r.ctrl[WSD_CTRL_TIME_MARK])
        begin
            if (rise)
            begin
                next_r.time_mark = 1'b1;
                next_r.marks     = wsd_inc(r.marks);
            end
        end
        else if (edge_hit)
        begin
            next_r.tick  = 1'b1;
            next_r.ticks = wsd_inc(r.ticks);
        end

        // ------------------------------------------------------------
        // apb slave, one wait state
        // ------------------------------------------------------------
        wr_ok          = 1'b0;
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        // decode on the access edge, answer one cycle later
        unique case (r.bus)
            WSD_IDLE:
            begin
                if (PSEL && !PENABLE)
                    next_r.bus = WSD_ACCESS;
            end
            WSD_ACCESS:
            begin
                if (r.pready)
                    next_r.bus = WSD_IDLE;
                else
                begin
                    next_r.pready = 1'b1;
                    next_r.prdata = WSD_ZERO;
                    wr_ok         = PWRITE;
                    unique case (PADDR)
                        WSD_CTRL_ADDR:   next_r.prdata[WSD_CTRL_W-1:0] = r.ctrl;
                        WSD_STATUS_ADDR: next_r.prdata = wsd_status(r.pol_learned, r.polarity, fwd_now, sp_now);
                        WSD_TICKS_ADDR:  next_r.prdata = wsd_zext(r.ticks);
                        WSD_MARKS_ADDR:  next_r.prdata = wsd_zext(r.marks);
                        default:
                        begin
                            next_r.pslverr = 1'b1;
                            wr_ok          = 1'b0;
                        end
                    endcase

                    // --------------------------------------------------------
                    // control write
                    // --------------------------------------------------------
                    if (wr_ok && PADDR == WSD_CTRL_ADDR)
                    begin
                        next_r.ctrl = PWDATA[WSD_CTRL_W-1:0];
                        next_r.ctrl[WSD_CTRL_CLR_CNT] = 1'b0;
                        if (PWDATA[WSD_CTRL_CLR_CNT])
                        begin
                            // set wins: events of the clear cycle stay
                            next_r.ticks       = CNT_W'(next_r.tick);
                            next_r.marks       = CNT_W'(next_r.time_mark);
                            next_r.pol_learned = next_r.pol_learned & ~r.pol_learned;
                        end
                    end
                end
            end
            // unused enum codes fall back to idle
            default:
                next_r.bus = WSD_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            r      <= '0;
            r.ctrl <= WSD_CTRL_RESET;
            r.bus  <= WSD_IDLE;
        end
        else
            r <= next_r;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign PRDATA       = r.prdata;
    assign PREADY       = r.pready;
    assign PSLVERR      = r.pslverr;
    assign TICK         = r.tick;
    assign TICK_FORWARD = r.tick_fwd;
    assign TIME_MARK    = r.time_mark;

endmodule // wsd_input

// *** rtl/wsd_pkg.sv ***
// constants and types for the wheel speed and direction input block
package wsd_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] WSD_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] WSD_STATUS_ADDR = 12'h004;
    localparam logic [11:0] WSD_TICKS_ADDR  = 12'h008;
    localparam logic [11:0] WSD_MARKS_ADDR  = 12'h00C;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    localparam int WSD_CTRL_DUAL_EDGE = 0;
    localparam int WSD_CTRL_TIME_MARK = 1;
    localparam int WSD_CTRL_POL_MAN   = 2;
    localparam int WSD_CTRL_POL_VAL   = 3;
    localparam int WSD_CTRL_DIR_SW    = 4;
    localparam int WSD_CTRL_DIR_SWVAL = 5;
    localparam int WSD_CTRL_SPD_OK    = 6;
    localparam int WSD_CTRL_CLR_CNT   = 7;
    localparam int WSD_CTRL_W         = 8;
    localparam logic [WSD_CTRL_W-1:0] WSD_CTRL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // status fields
    // ----------------------------------------------------------------
    localparam int WSD_ST_POL_LEARNED = 0;
    localparam int WSD_ST_POLARITY    = 1;
    localparam int WSD_ST_FORWARD     = 2;
    localparam int WSD_ST_PULSE_LVL   = 3;

    localparam logic [31:0] WSD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {WSD_IDLE, WSD_ACCESS} wsd_bus_t;

endpackage : wsd_pkg

// *** testbench/wheel_speed_direction_input_tb.sv ***
// self-checking bench for the wheel speed and direction input block
`timescale 1ns/1ps
module wheel_speed_direction_input_tb
    import wsd_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, r;
    logic        pready, pslverr, tick, direction_input, mark, spd, dir, e, x;
    logic [7:0]  dm [4] = '{8'h0C, 8'h04, 8'h30, 8'h10};
    int          failures = 0;
    int          tests_run = 0;
    int          exp_t = 0;
    int          exp_m = 0;
    int          k;
    int          seed = 32'h7783;
    int          seen_t = 0;
    int          seen_m = 0;
    always #4 clock = ~clock;
    wsd_sensor i_sen (.CLOCK(clock), .SPD(spd), .DIR(dir));
    wsd_input i_dut (.CLOCK(clock), .RST_B(rst_b), .SPEED_PULSE_INPUT(spd), .DIRECTION_INPUT(dir),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TICK(tick), .TICK_FORWARD(direction_input), .TIME_MARK(mark));
    // event pulses counted mid-cycle, where they stand
    always @(negedge clock)
    begin
        if (tick === 1'b1) seen_t++;
        if (mark === 1'b1) seen_m++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        failures++;
        finish_test;
    end
    initial
    begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, WSD_CTRL_ADDR, 0);
        chk(r, 0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk({31'h0, e}, 1);
        apb(1'b0, WSD_CTRL_ADDR, 0);
        chk(r, 0);
        $display("test registers done");
        for (int c = 0; c < 3; c++)
        begin
            apb(1'b1, WSD_CTRL_ADDR, c);
            k = 1 + $unsigned($random(seed)) % 3;
            repeat (k) i_sen.pulse(8 + $unsigned($random(seed)) % 4);
            if (c == 2) exp_m += k;
            else exp_t += k * (c + 1);
            apb(1'b0, WSD_TICKS_ADDR, 0);
            chk(r, exp_t);
            apb(1'b0, WSD_MARKS_ADDR, 0);
            chk(r, exp_m);
            chk(seen_t, exp_t);
            chk(seen_m, exp_m);
        end
        $display("test counting done");
        foreach (dm[i]) for (int d = 0; d < 2; d++)
        begin
            apb(1'b1, WSD_CTRL_ADDR, dm[i]);
            i_sen.set_dir(d[0]);
            repeat (4) @(posedge clock);
            x = dm[i][4] ? dm[i][5] : !(d[0] ^ dm[i][3]);
            chk({31'h0, direction_input}, {31'h0, x});
            apb(1'b0, WSD_STATUS_ADDR, 0);
            chk({31'h0, r[WSD_ST_FORWARD]}, {31'h0, x});
            chk({31'h0, r[WSD_ST_PULSE_LVL]}, 0);
        end
        $display("test direction done");
        apb(1'b1, WSD_CTRL_ADDR, 32'h80);
        apb(1'b0, WSD_TICKS_ADDR, 0);
        chk(r, 0);
        i_sen.set_dir(1'b1);
        i_sen.pulse(8);
        apb(1'b0, WSD_STATUS_ADDR, 0);
        chk({31'h0, r[WSD_ST_POL_LEARNED]}, 0);
        apb(1'b1, WSD_CTRL_ADDR, 32'h40);
        i_sen.pulse(9);
        apb(1'b0, WSD_STATUS_ADDR, 0);
        chk({30'h0, r[1:0]}, 3);
        i_sen.set_dir(1'b0);
        repeat (4) @(posedge clock);
        chk({31'h0, direction_input}, 0);
        $display("test learning done");
        finish_test;
    end
endmodule // wheel_speed_direction_input_tb

// *** testbench/wsd_chk.sv ***
// port assertions for the wheel speed and direction input block
`timescale 1ns/1ps
module wsd_chk
    import wsd_pkg::*;
(
    // clock, reset and pins
    input wire logic        CLOCK,
    input wire logic        RST_B,
    input wire logic        SPEED_PULSE_INPUT,
    input wire logic        DIRECTION_INPUT,
    // apb and events
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        TICK,
    input wire logic        TICK_FORWARD,
    input wire logic        TIME_MARK
);
    logic [7:0] ctrl;
    logic [3:0] quiet;
    logic       dir_q;
    // shadow of control, cycles since last write or direction change
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctrl  <= 8'h00;
            quiet <= 4'h0;
            dir_q <= 1'b0;
        end
        else
        begin
            dir_q <= DIRECTION_INPUT;
            if (PSEL && PENABLE && PWRITE && PREADY && PADDR == WSD_CTRL_ADDR)
                ctrl <= PWDATA[7:0];
            if ((PSEL && PWRITE) || dir_q != DIRECTION_INPUT)
                quiet <= 4'h0;
            else if (quiet != 4'h8)
                quiet <= quiet + 4'h1;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    sequence s_no_tick;
        !TICK [*4];
    endsequence
    chk_rise_tick: assert property ($rose(SPEED_PULSE_INPUT) && !ctrl[1] |-> ##[2:5] TICK)
        else $error("no tick after rising edge");
    chk_fall_skip: assert property ($fell(SPEED_PULSE_INPUT) && !ctrl[0] && !ctrl[1] |-> ##2 s_no_tick)
        else $error("tick after falling edge");
    chk_dual_fall: assert property ($fell(SPEED_PULSE_INPUT) && ctrl[0] && !ctrl[1] |-> ##[2:5] TICK)
        else $error("no tick after falling edge");
    chk_mark_rise: assert property ($rose(SPEED_PULSE_INPUT) && ctrl[1] |-> ##[2:5] TIME_MARK)
        else $error("no time mark");
    chk_mark_quiet: assert property ($rose(SPEED_PULSE_INPUT) && ctrl[1] |-> ##2 s_no_tick)
        else $error("tick in time mark mode");
    chk_sync_delay: assert property ($rose(SPEED_PULSE_INPUT) |-> !TICK [*2])
        else $error("tick before synchroniser");
    chk_man_pol: assert property (quiet == 4'h8 && $stable(DIRECTION_INPUT) && ctrl[2] && !ctrl[4]
        |-> TICK_FORWARD == !(DIRECTION_INPUT ^ ctrl[3]))
        else $error("manual polarity ignored");
    chk_sw_dir: assert property (quiet == 4'h8 && ctrl[4] |-> TICK_FORWARD == ctrl[5])
        else $error("software direction ignored");
endmodule // wsd_chk
bind wsd_input wsd_chk i_chk (.CLOCK(CLOCK), .RST_B(RST_B), .SPEED_PULSE_INPUT(SPEED_PULSE_INPUT),
    .DIRECTION_INPUT(DIRECTION_INPUT), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .TICK(TICK), .TICK_FORWARD(TICK_FORWARD), .TIME_MARK(TIME_MARK));

// *** testbench/wsd_sensor.sv ***
// wheel speed sensor and direction signal model
`timescale 1ns/1ps
module wsd_sensor (
    // clock and pins
    input wire logic CLOCK,
    output logic     SPD,
    output logic     DIR
);
    // ten microseconds of the 8 ns clock
    localparam int CLK_NS    = 8;
    localparam int MIN_PULSE = 10_000 / CLK_NS;
    initial
    begin
        SPD = 1'b0;
        DIR = 1'b0;
    end
    task automatic pulse(input int w);
        @(posedge CLOCK);
        SPD <= 1'b1;
        repeat (MIN_PULSE + w) @(posedge CLOCK);
        SPD <= 1'b0;
        repeat (MIN_PULSE + w) @(posedge CLOCK);
    endtask
    task automatic set_dir(input logic d);
        @(posedge CLOCK);
        DIR <= d;
    endtask
endmodule // wsd_sensor
